// ==== logic/oms_pkg.sv ====
// Constants, field layouts and state codes of the oscillator mode select block
`default_nettype none
package oms_pkg;
	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [7:0] OMS_OFF_CFG = 8'h00;
	localparam logic [7:0] OMS_OFF_CTRL = 8'h04;
	localparam logic [7:0] OMS_OFF_STATUS = 8'h08;
	localparam logic [7:0] OMS_OFF_IRQ_STAT = 8'h0c;
	localparam logic [7:0] OMS_OFF_IRQ_CLR = 8'h10;
	localparam logic [7:0] OMS_OFF_IRQ_EN = 8'h14;
	localparam logic [7:0] OMS_OFF_POWER = 8'h18;
	localparam logic [7:0] OMS_OFF_ID = 8'h1c;

	// ****************************************
	// Configuration straps and control fields
	// ****************************************
	localparam int OMS_CFG_W = 7;
	localparam int OMS_CFG_MODE_LSB = 0;
	localparam int OMS_CFG_PWRUP_EN_BIT = 3;
	localparam int OMS_CFG_MULT_EN_BIT = 4;
	localparam int OMS_CFG_CLKOUT_N_BIT = 5;
	localparam int OMS_CFG_FAILMON_BIT = 6;
	localparam int OMS_CTRL_W = 7;
	localparam int OMS_CTRL_SEL_LSB = 0;
	localparam int OMS_CTRL_SOFT_MULT_BIT = 2;
	localparam int OMS_CTRL_GPIO_O_BIT = 3;
	localparam int OMS_CTRL_GPIO_OE_BIT = 4;
	localparam int OMS_CTRL_INT_LSB = 5;
	localparam logic [6:0] OMS_CTRL_RESET = 7'h00;
	localparam int OMS_IRQ_W = 3;
	localparam int OMS_IRQ_STARTUP = 0;
	localparam int OMS_IRQ_FAIL = 1;
	localparam int OMS_IRQ_SWITCH = 2;
	// Identification value is arbitrary
	localparam logic [31:0] OMS_ID_VALUE = 32'h00c1_0c5e;

	// ****************************************
	// Mode field codes
	// ****************************************
	localparam logic [2:0] OMS_MODE_EXT_HI = 3'h7;
	localparam logic [2:0] OMS_MODE_EXT_MID = 3'h6;
	localparam logic [2:0] OMS_MODE_EXT_LO = 3'h5;
	localparam logic [2:0] OMS_MODE_INTERNAL = 3'h4;
	localparam logic [2:0] OMS_MODE_RC = 3'h3;
	localparam logic [2:0] OMS_MODE_XTAL_HI = 3'h2;
	localparam logic [2:0] OMS_MODE_XTAL_MID = 3'h1;
	localparam logic [2:0] OMS_MODE_XTAL_LO = 3'h0;

	// ****************************************
	// Timing
	// ****************************************
	localparam int unsigned OMS_HCLK_PERIOD_PS = 4000;
	localparam int unsigned OMS_FAST_PERIOD_PS = 62500;
	localparam int unsigned OMS_MED_PERIOD_PS = 2000000;
	localparam int unsigned OMS_SLOW_PERIOD_PS = 32258065;
	localparam int unsigned OMS_FAST_DIV = OMS_FAST_PERIOD_PS / OMS_HCLK_PERIOD_PS;
	localparam int unsigned OMS_MED_DIV = OMS_MED_PERIOD_PS / OMS_HCLK_PERIOD_PS;
	localparam int unsigned OMS_SLOW_DIV = OMS_SLOW_PERIOD_PS / OMS_HCLK_PERIOD_PS;
	localparam int unsigned OMS_STARTUP_COUNT = 1024;
	localparam int unsigned OMS_PWRUP_TICKS = 64;
	localparam logic [1:0] OMS_FAIL_TICKS = 2'h2;
	localparam logic [1:0] OMS_CAPTURE_CYCLES = 2'h2;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [4:0] {
		OMS_ST_CAPTURE = 5'h01,
		OMS_ST_PWRUP = 5'h02,
		OMS_ST_STARTUP = 5'h04,
		OMS_ST_RUN = 5'h08,
		OMS_ST_SLEEP = 5'h10
	} oms_state_t;
	typedef enum logic [1:0] {
		OMS_SRC_EXT = 2'h0,
		OMS_SRC_T1 = 2'h1,
		OMS_SRC_INT = 2'h2
	} oms_src_t;
endpackage
`default_nettype wire

// ==== logic/oms_tick_div.sv ====
// Free-running divider that gives one tick pulse every DIV clock cycles
`default_nettype none
module oms_tick_div #(
	parameter int unsigned DIV = 16
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	// Tick
	output logic tick
);
	localparam int CW = $clog2(DIV + 1);
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	logic [CW-1:0] cnt_ff, nxt_cnt;
	logic tick_ff, nxt_tick;

	always_comb begin
		nxt_tick = 1'b0;
		nxt_cnt = cnt_ff + CW'(1);
		if (cnt_ff == LAST) begin
			nxt_cnt = '0;
			nxt_tick = 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_ff <= '0;
			tick_ff <= 1'b0;
		end else if (clk_en) begin
			cnt_ff <= nxt_cnt;
			tick_ff <= nxt_tick;
		end
	end

	assign tick = tick_ff;
endmodule
`default_nettype wire

// ==== logic/oms_event_count.sv ====
// Counter of input events that raises done once TARGET events are seen
`default_nettype none
module oms_event_count #(
	parameter int unsigned TARGET = 1024
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	// Control
	input wire logic clear,
	input wire logic event_in,
	output logic done
);
	localparam int CW = $clog2(TARGET + 1);
	localparam logic [CW-1:0] FULL = CW'(TARGET);

	logic [CW-1:0] cnt_ff, nxt_cnt;
	logic done_ff, nxt_done;

	always_comb begin
		nxt_cnt = cnt_ff;
		if (clear) begin
			nxt_cnt = '0;
		end else if (event_in && cnt_ff != FULL) begin
			nxt_cnt = cnt_ff + CW'(1);
		end
		nxt_done = !clear && nxt_cnt == FULL;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_ff <= '0;
			done_ff <= 1'b0;
		end else if (clk_en) begin
			cnt_ff <= nxt_cnt;
			done_ff <= nxt_done;
		end
	end

	assign done = done_ff;
endmodule
`default_nettype wire

// ==== logic/oms_osc_ctrl.sv ====
// Oscillator mode select, start-up timing, multiplier enable and clock failure monitor
`default_nettype none
module oms_osc_ctrl
	import oms_pkg::*;
#(
	parameter int unsigned FAST_DIV = OMS_FAST_DIV,
	parameter int unsigned MED_DIV = OMS_MED_DIV,
	parameter int unsigned SLOW_DIV = OMS_SLOW_DIV,
	parameter int unsigned STARTUP_COUNT = OMS_STARTUP_COUNT,
	parameter int unsigned PWRUP_TICKS = OMS_PWRUP_TICKS
) (
	// Clock, reset, enable
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Pins and straps
	input wire logic [OMS_CFG_W-1:0] cfg_strap,
	input wire logic osc_in_pin,
	input wire logic t1osc_in,
	input wire logic wake_in,
	input wire logic osc_out_pin_i,
	output logic osc_out_pin_o,
	output logic osc_out_pin_oe,
	// Core side
	output logic core_hold,
	output logic core_tick,
	output logic [1:0] sys_src,
	output logic multiplier_on,
	output logic [1:0] amp_gain,
	output logic irq
);
	// ****************************************
	// Input synchronisers
	// ****************************************
	localparam int SW = OMS_CFG_W + 4;
	logic [SW-1:0] s1_ff, s2_ff;
	logic [1:0] s3_ff;
	logic osc_edge, t1_edge, wake_s, pin_s;
	logic [OMS_CFG_W-1:0] strap_s;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
		end else if (clk_en) begin
			s1_ff <= {cfg_strap, osc_out_pin_i, wake_in, t1osc_in, osc_in_pin};
			s2_ff <= s1_ff;
			s3_ff <= s2_ff[1:0];
		end
	end

	assign osc_edge = s2_ff[0] && !s3_ff[0];
	assign t1_edge = s2_ff[1] && !s3_ff[1];
	assign wake_s = s2_ff[2];
	assign pin_s = s2_ff[3];
	assign strap_s = s2_ff[SW-1:4];

	// ****************************************
	// Internal sources
	// ****************************************
	localparam int unsigned DIVS [3] = '{FAST_DIV, MED_DIV, SLOW_DIV};
	logic [2:0] int_tick;

	for (genvar g = 0; g < 3; g++) begin : g_int
		oms_tick_div #(.DIV(DIVS[g])) u_div (
			.hclk(hclk),
			.hresetn(hresetn),
			.clk_en(clk_en),
			.tick(int_tick[g])
		);
	end

	// ****************************************
	// Register declarations
	// ****************************************
	oms_state_t state_ff, nxt_state;
	logic [1:0] cap_cnt_ff, nxt_cap_cnt;
	logic [OMS_CFG_W-1:0] cfg_ff, nxt_cfg;
	logic [OMS_CTRL_W-1:0] ctrl_ff, nxt_ctrl;
	logic [OMS_IRQ_W-1:0] irq_stat_ff, nxt_irq_stat, irq_en_ff, nxt_irq_en;
	logic [1:0] mon_cnt_ff, nxt_mon_cnt;
	logic fail_ff, nxt_fail;
	logic wr_pend_ff, nxt_wr_pend;
	logic [7:0] wr_addr_ff, nxt_wr_addr;
	logic [31:0] hrdata_ff, nxt_hrdata;
	logic hready_ff;
	logic hold_ff, nxt_hold, tick_ff, nxt_tick, mult_ff, nxt_mult;
	logic [1:0] src_ff, nxt_src, gain_ff, nxt_gain;
	logic pin_o_ff, nxt_pin_o, pin_oe_ff, nxt_pin_oe, irq_ff, nxt_irq;

	// ****************************************
	// Mode decode
	// ****************************************
	logic [2:0] mode;
	logic is_xtal, is_ext_logic, is_internal;
	logic xtal_cnt_clear, xtal_cnt_done, pwr_clear, pwr_done, start_evt;
	logic [1:0] sel;
	logic [1:0] int_sel;
	logic src_tick;

	assign mode = cfg_ff[OMS_CFG_MODE_LSB +: 3];
	assign is_xtal = mode == OMS_MODE_XTAL_LO || mode == OMS_MODE_XTAL_MID
		|| mode == OMS_MODE_XTAL_HI;
	assign is_ext_logic = mode == OMS_MODE_EXT_HI || mode == OMS_MODE_EXT_MID
		|| mode == OMS_MODE_EXT_LO;
	assign is_internal = mode == OMS_MODE_INTERNAL;
	assign sel = ctrl_ff[OMS_CTRL_SEL_LSB +: 2];
	assign int_sel = ctrl_ff[OMS_CTRL_INT_LSB +: 2];

	// ****************************************
	// Start-up timers
	// ****************************************
	// Both counters are held at zero outside their own state and restart from zero on every entry to it
	oms_event_count #(.TARGET(STARTUP_COUNT)) u_xtal_cnt (
		.hclk(hclk),
		.hresetn(hresetn),
		.clk_en(clk_en),
		.clear(xtal_cnt_clear),
		.event_in(osc_edge),
		.done(xtal_cnt_done)
	);

	oms_event_count #(.TARGET(PWRUP_TICKS)) u_pwrup (
		.hclk(hclk),
		.hresetn(hresetn),
		.clk_en(clk_en),
		.clear(pwr_clear),
		.event_in(int_tick[2]),
		.done(pwr_done)
	);

	assign xtal_cnt_clear = state_ff != OMS_ST_STARTUP;
	assign pwr_clear = state_ff != OMS_ST_PWRUP;

	// ****************************************
	// Sequencer
	// ****************************************
	always_comb begin
		nxt_state = state_ff;
		nxt_cap_cnt = cap_cnt_ff;
		nxt_cfg = cfg_ff;
		start_evt = 1'b0;
		case (state_ff)
			OMS_ST_CAPTURE: begin
				// Straps are read only after they have crossed the synchroniser
				if (cap_cnt_ff == OMS_CAPTURE_CYCLES) begin
					nxt_cfg = strap_s;
					if (strap_s[OMS_CFG_PWRUP_EN_BIT]) begin
						nxt_state = OMS_ST_PWRUP;
					end else if (strap_s[2:0] <= OMS_MODE_XTAL_HI) begin
						nxt_state = OMS_ST_STARTUP;
					end else begin
						nxt_state = OMS_ST_RUN;
						start_evt = 1'b1;
					end
				end else begin
					nxt_cap_cnt = cap_cnt_ff + 2'h1;
				end
			end
			OMS_ST_PWRUP: begin
				if (pwr_done) begin
					nxt_state = is_xtal ? OMS_ST_STARTUP : OMS_ST_RUN;
					start_evt = !is_xtal;
				end
			end
			OMS_ST_STARTUP: begin
				if (xtal_cnt_done || fail_ff) begin
					nxt_state = OMS_ST_RUN;
					start_evt = 1'b1;
				end
			end
			OMS_ST_RUN: begin
				if (wr_pend_ff && wr_addr_ff == OMS_OFF_POWER && hwdata[0]) begin
					nxt_state = OMS_ST_SLEEP;
				end
			end
			OMS_ST_SLEEP: begin
				if (wake_s) begin
					nxt_state = is_xtal ? OMS_ST_STARTUP : OMS_ST_RUN;
					start_evt = !is_xtal;
				end
			end
			default: begin
				nxt_state = OMS_ST_CAPTURE;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_ff <= OMS_ST_CAPTURE;
			cap_cnt_ff <= 2'h0;
			cfg_ff <= '0;
		end else if (clk_en) begin
			state_ff <= nxt_state;
			cap_cnt_ff <= nxt_cap_cnt;
			cfg_ff <= nxt_cfg;
		end
	end

	// ****************************************
	// Clock failure monitor and source choice
	// ****************************************
	logic monitoring;
	assign monitoring = cfg_ff[OMS_CFG_FAILMON_BIT] && !is_internal
		&& (state_ff == OMS_ST_RUN || state_ff == OMS_ST_STARTUP);

	always_comb begin
		nxt_mon_cnt = mon_cnt_ff;
		nxt_fail = fail_ff;
		if (osc_edge || !monitoring) begin
			nxt_mon_cnt = 2'h0;
		end else if (int_tick[2] && mon_cnt_ff != OMS_FAIL_TICKS) begin
			nxt_mon_cnt = mon_cnt_ff + 2'h1;
		end
		if (monitoring && mon_cnt_ff == OMS_FAIL_TICKS) begin
			nxt_fail = 1'b1;
		end
		// Fallback only applies while the configured external source is in use
		if (is_internal || sel[1]) begin
			nxt_src = OMS_SRC_INT;
		end else if (sel == 2'h1) begin
			nxt_src = OMS_SRC_T1;
		end else if (fail_ff) begin
			nxt_src = OMS_SRC_INT;
		end else begin
			nxt_src = OMS_SRC_EXT;
		end
		case (src_ff)
			OMS_SRC_EXT: src_tick = osc_edge;
			OMS_SRC_T1: src_tick = t1_edge;
			default: src_tick = int_sel == 2'h0 ? int_tick[0]
				: (int_sel == 2'h1 ? int_tick[1] : int_tick[2]);
		endcase
		nxt_hold = state_ff != OMS_ST_RUN;
		nxt_tick = !nxt_hold && src_tick;
		nxt_mult = cfg_ff[OMS_CFG_MULT_EN_BIT] || ctrl_ff[OMS_CTRL_SOFT_MULT_BIT];
		case (mode)
			OMS_MODE_XTAL_LO: nxt_gain = 2'h1;
			OMS_MODE_XTAL_MID: nxt_gain = 2'h2;
			OMS_MODE_XTAL_HI: nxt_gain = 2'h3;
			default: nxt_gain = 2'h0;
		endcase
		// Crystal modes leave the pin to the amplifier
		nxt_pin_o = pin_o_ff;
		nxt_pin_oe = 1'b0;
		if (!is_xtal && !cfg_ff[OMS_CFG_CLKOUT_N_BIT]) begin
			nxt_pin_oe = 1'b1;
			nxt_pin_o = tick_ff ? !pin_o_ff : pin_o_ff;
		end else if (!is_xtal) begin
			nxt_pin_oe = ctrl_ff[OMS_CTRL_GPIO_OE_BIT];
			nxt_pin_o = ctrl_ff[OMS_CTRL_GPIO_O_BIT];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mon_cnt_ff <= 2'h0;
			fail_ff <= 1'b0;
			src_ff <= OMS_SRC_EXT;
			hold_ff <= 1'b1;
			tick_ff <= 1'b0;
			mult_ff <= 1'b0;
			gain_ff <= 2'h0;
			pin_o_ff <= 1'b0;
			pin_oe_ff <= 1'b0;
		end else if (clk_en) begin
			mon_cnt_ff <= nxt_mon_cnt;
			fail_ff <= nxt_fail;
			src_ff <= nxt_src;
			hold_ff <= nxt_hold;
			tick_ff <= nxt_tick;
			mult_ff <= nxt_mult;
			gain_ff <= nxt_gain;
			pin_o_ff <= nxt_pin_o;
			pin_oe_ff <= nxt_pin_oe;
		end
	end

	// ****************************************
	// AHB-Lite register slave
	// ****************************************
	logic addr_valid;
	logic [OMS_IRQ_W-1:0] irq_set, irq_clr;
	assign addr_valid = hsel && htrans[1] && hready;
	assign irq_set = {src_ff != nxt_src, nxt_fail && !fail_ff, start_evt};
	assign irq_clr = (wr_pend_ff && wr_addr_ff == OMS_OFF_IRQ_CLR)
		? hwdata[OMS_IRQ_W-1:0] : '0;

	function automatic logic [31:0] read_mux(input logic [7:0] a);
		logic [31:0] r;
		r = '0;
		case (a)
			OMS_OFF_CFG: r[OMS_CFG_W-1:0] = cfg_ff;
			OMS_OFF_CTRL: r[OMS_CTRL_W-1:0] = ctrl_ff;
			OMS_OFF_STATUS: r[9:0] = {pin_s, fail_ff, mult_ff, gain_ff,
				state_ff == OMS_ST_STARTUP, hold_ff, state_ff == OMS_ST_SLEEP, src_ff};
			OMS_OFF_IRQ_STAT: r[OMS_IRQ_W-1:0] = irq_stat_ff;
			OMS_OFF_IRQ_EN: r[OMS_IRQ_W-1:0] = irq_en_ff;
			OMS_OFF_ID: r = OMS_ID_VALUE;
			default: r = '0;
		endcase
		return r;
	endfunction

	always_comb begin
		nxt_wr_pend = addr_valid && hwrite;
		nxt_wr_addr = addr_valid ? haddr[7:0] : wr_addr_ff;
		nxt_hrdata = (addr_valid && !hwrite) ? read_mux(haddr[7:0]) : '0;
		nxt_ctrl = ctrl_ff;
		nxt_irq_en = irq_en_ff;
		if (wr_pend_ff && wr_addr_ff == OMS_OFF_CTRL) begin
			nxt_ctrl = hwdata[OMS_CTRL_W-1:0];
		end
		if (wr_pend_ff && wr_addr_ff == OMS_OFF_IRQ_EN) begin
			nxt_irq_en = hwdata[OMS_IRQ_W-1:0];
		end
		// A new event beats a clear in the same cycle
		nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_set;
		nxt_irq = |(nxt_irq_stat & nxt_irq_en);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
			hrdata_ff <= 32'h0000_0000;
			hready_ff <= 1'b0;
			ctrl_ff <= OMS_CTRL_RESET;
			irq_en_ff <= '0;
			irq_stat_ff <= '0;
			irq_ff <= 1'b0;
		end else if (clk_en) begin
			wr_pend_ff <= nxt_wr_pend;
			wr_addr_ff <= nxt_wr_addr;
			hrdata_ff <= nxt_hrdata;
			hready_ff <= 1'b1;
			ctrl_ff <= nxt_ctrl;
			irq_en_ff <= nxt_irq_en;
			irq_stat_ff <= nxt_irq_stat;
			irq_ff <= nxt_irq;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign hreadyout = hready_ff;
	assign hresp = 1'b0;
	assign hrdata = hrdata_ff;
	assign osc_out_pin_o = pin_o_ff;
	assign osc_out_pin_oe = pin_oe_ff;
	assign core_hold = hold_ff;
	assign core_tick = tick_ff;
	assign sys_src = src_ff;
	assign multiplier_on = mult_ff;
	assign amp_gain = gain_ff;
	assign irq = irq_ff;
endmodule
`default_nettype wire

// ==== tb/oms_osc_ctrl_checker.sv ====
// Concurrent assertions on the ports of the oscillator mode select block
`default_nettype none
module oms_osc_ctrl_checker
	import oms_pkg::*;
#(
	parameter int unsigned STARTUP_COUNT = OMS_STARTUP_COUNT
) (
	// Clock, reset, enable
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	// Straps and pins
	input wire logic [OMS_CFG_W-1:0] cfg_strap,
	input wire logic osc_in_pin,
	input wire logic osc_out_pin_oe,
	// Bus and core side
	input wire logic [31:0] hrdata,
	input wire logic core_hold,
	input wire logic core_tick,
	input wire logic [1:0] sys_src,
	input wire logic multiplier_on,
	input wire logic [1:0] amp_gain
);
	logic xtal, ext_clk, run2, osc_prev_ff, hold_prev_ff;
	logic [11:0] edge_cnt_ff, nxt_edge_cnt;
	assign xtal = cfg_strap[2:0] <= OMS_MODE_XTAL_HI;
	assign ext_clk = cfg_strap[2:0] >= OMS_MODE_EXT_LO;
	assign run2 = !core_hold && !hold_prev_ff;
	// Raw pin edges bound from above what the synchroniser can have counted
	always_comb begin
		nxt_edge_cnt = edge_cnt_ff;
		if (core_hold && !hold_prev_ff)
			nxt_edge_cnt = 12'h000;
		else if (osc_in_pin && !osc_prev_ff && edge_cnt_ff != 12'hfff)
			nxt_edge_cnt = edge_cnt_ff + 12'h001;
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			edge_cnt_ff <= 12'h000;
			osc_prev_ff <= 1'b0;
			hold_prev_ff <= 1'b1;
		end else begin
			edge_cnt_ff <= nxt_edge_cnt;
			osc_prev_ff <= osc_in_pin;
			hold_prev_ff <= core_hold;
		end
	end
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	property p_gain;
		run2 |-> amp_gain == (xtal ? cfg_strap[1:0] + 2'h1 : 2'h0);
	endproperty
	a_gain: assert property (p_gain) else $error("amplifier gain wrong for mode");
	property p_mult;
		run2 && cfg_strap[OMS_CFG_MULT_EN_BIT] |-> multiplier_on;
	endproperty
	a_mult: assert property (p_mult) else $error("multiplier off with strap set");
	property p_hold_tick;
		core_hold && hold_prev_ff |-> !core_tick;
	endproperty
	a_hold_tick: assert property (p_hold_tick) else $error("core tick while held");
	property p_extclk_fast;
		$rose(hresetn) && ext_clk && !cfg_strap[OMS_CFG_PWRUP_EN_BIT] |-> ##[1:12] !core_hold;
	endproperty
	a_extclk_fast: assert property (p_extclk_fast) else $error("external clock start delayed");
	property p_startup;
		$fell(core_hold) && xtal && !cfg_strap[OMS_CFG_FAILMON_BIT]
			|-> edge_cnt_ff >= STARTUP_COUNT;
	endproperty
	a_startup: assert property (p_startup) else $error("core released before full count");
	property p_oe_xtal;
		run2 && xtal |-> !osc_out_pin_oe;
	endproperty
	a_oe_xtal: assert property (p_oe_xtal) else $error("output pin driven in crystal mode");
	property p_clkout;
		run2 && !xtal && cfg_strap[2:0] != OMS_MODE_INTERNAL
			&& !cfg_strap[OMS_CFG_CLKOUT_N_BIT] |-> osc_out_pin_oe;
	endproperty
	a_clkout: assert property (p_clkout) else $error("clock out not driven");
	property p_freeze;
		!clk_en |=> $stable(core_hold) && $stable(sys_src) && $stable(core_tick) && $stable(hrdata);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved with clock stopped");
endmodule
bind oms_osc_ctrl oms_osc_ctrl_checker #(.STARTUP_COUNT(STARTUP_COUNT))
	i_oms_osc_ctrl_checker (
	.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .cfg_strap(cfg_strap),
	.osc_in_pin(osc_in_pin), .osc_out_pin_oe(osc_out_pin_oe), .hrdata(hrdata),
	.core_hold(core_hold), .core_tick(core_tick), .sys_src(sys_src),
	.multiplier_on(multiplier_on), .amp_gain(amp_gain)
);
`default_nettype wire

// ==== tb/oms_ext_osc_model.sv ====
// Behavioural external clock source that can be stopped and restarted
`default_nettype none
module oms_ext_osc_model #(
	parameter real HALF_NS = 12.3
) (
	// Control and clock
	input wire logic run,
	output logic osc
);
	timeunit 1ns;
	timeprecision 1ps;
	// A 12.3 ns half period puts only one edge in 20 on a bus clock edge; a stopped source parks its line
	initial begin
		osc = 1'b0;
		forever begin
			wait (run === 1'b1);
			#(HALF_NS) osc = ~osc;
		end
	end
endmodule
`default_nettype wire

// ==== tb/tb_oms_osc_ctrl.sv ====
// Self-checking testbench of the oscillator mode select block
`default_nettype none
`define CHK(got, exp) begin \
	total_checks++; \
	if ((got) !== (exp)) begin \
		mismatches++; \
		$display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); \
	end \
end
module tb_oms_osc_ctrl import oms_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int STARTUP_EDGES = 8;
	int mismatches = 0;
	int total_checks = 0;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic clk_en = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [6:0] cfg_strap = 7'h0;
	logic t1osc_in = 1'b0;
	logic wake_in = 1'b0;
	logic osc_run = 1'b1;
	logic [2:0] t1_div = 3'h0;
	logic hreadyout, hresp, osc_in_pin, osc_out_pin_i, osc_out_pin_o, osc_out_pin_oe;
	logic core_hold, core_tick, multiplier_on, irq;
	logic [1:0] sys_src, amp_gain;
	logic [31:0] hrdata, rd;
	always #2 hclk = ~hclk;
	// Pull-up keeps a released pin high
	assign osc_out_pin_i = osc_out_pin_oe ? osc_out_pin_o : 1'b1;
	always @(posedge hclk) begin
		t1_div <= t1_div + 3'h1;
		t1osc_in <= t1_div[2];
	end
	oms_ext_osc_model i_oms_ext_osc_model (.run(osc_run), .osc(osc_in_pin));
	oms_osc_ctrl #(.FAST_DIV(3), .MED_DIV(5), .SLOW_DIV(8), .STARTUP_COUNT(STARTUP_EDGES),
		.PWRUP_TICKS(2))
	i_oms_osc_ctrl (
		.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cfg_strap(cfg_strap),
		.osc_in_pin(osc_in_pin), .t1osc_in(t1osc_in), .wake_in(wake_in),
		.osc_out_pin_i(osc_out_pin_i), .osc_out_pin_o(osc_out_pin_o),
		.osc_out_pin_oe(osc_out_pin_oe), .core_hold(core_hold), .core_tick(core_tick),
		.sys_src(sys_src), .multiplier_on(multiplier_on), .amp_gain(amp_gain), .irq(irq)
	);
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 100);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 200);
		rd = hrdata;
		if (hreadyout !== 1'b1) mismatches++;
	endtask
	task automatic do_reset(input logic [6:0] cfg);
		hresetn <= 1'b0;
		cfg_strap <= cfg;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (3) @(posedge hclk);
	endtask
	task automatic wait_run(output int n);
		n = 0;
		while (core_hold !== 1'b0 && n < 3000) begin
			@(posedge hclk);
			n++;
		end
		if (n >= 3000) mismatches++;
		repeat (2) @(posedge hclk);
	endtask
	task automatic count_ticks(input int cyc, output int n);
		n = 0;
		repeat (cyc) begin
			@(posedge hclk);
			if (core_tick === 1'b1) n++;
		end
	endtask
	task automatic t_modes();
		int n;
		for (int m = 0; m < 8; m++) begin
			do_reset({4'h0, m[2:0]});
			wait_run(n);
			`CHK(core_hold, 1'b0)
			`CHK(n > 4 * STARTUP_EDGES, m < 3)
			`CHK(amp_gain, (m < 3) ? 2'(m + 1) : 2'h0)
			ahb(0, OMS_OFF_CFG, 0);
			`CHK(rd[6:0], {4'h0, m[2:0]})
		end
		// Power-up delay of two slow ticks comes first, then any crystal count
		do_reset(7'h0f);
		wait_run(n);
		`CHK(n > 8, 1'b1)
		do_reset(7'h09);
		wait_run(n);
		`CHK(n > 5 * STARTUP_EDGES, 1'b1)
		$display("test modes done");
	endtask
	task automatic t_hold_sleep();
		int n;
		osc_run <= 1'b0;
		do_reset(7'h01);
		repeat (200) @(posedge hclk);
		`CHK({core_hold, core_tick}, 2'h2)
		osc_run <= 1'b1;
		repeat (30) @(posedge hclk);
		do_reset(7'h01);
		wait_run(n);
		`CHK(n > 4 * STARTUP_EDGES, 1'b1)
		ahb(1, OMS_OFF_POWER, 1);
		repeat (4) @(posedge hclk);
		`CHK(core_hold, 1'b1)
		ahb(0, OMS_OFF_STATUS, 0);
		`CHK(rd[2], 1'b1)
		wake_in <= 1'b1;
		wait_run(n);
		wake_in <= 1'b0;
		`CHK(n > 4 * STARTUP_EDGES, 1'b1)
		$display("test hold and sleep done");
	endtask
	task automatic t_mult_pin();
		int n;
		do_reset(7'h17);
		wait_run(n);
		`CHK(multiplier_on, 1'b1)
		do_reset(7'h27);
		wait_run(n);
		`CHK({multiplier_on, osc_out_pin_oe}, 2'h0)
		ahb(1, OMS_OFF_CTRL, 32'h1c);
		repeat (2) @(posedge hclk);
		`CHK({multiplier_on, osc_out_pin_oe, osc_out_pin_o}, 3'h7)
		ahb(0, OMS_OFF_STATUS, 0);
		`CHK(rd[9:7], 3'h5)
		$display("test multiplier and pin done");
	endtask
	task automatic t_switch_irq();
		int n;
		int divs[3] = '{3, 5, 8};
		do_reset(7'h07);
		wait_run(n);
		ahb(0, OMS_OFF_CTRL, 0);
		`CHK(rd, 32'h0)
		ahb(0, OMS_OFF_IRQ_STAT, 0);
		`CHK(rd, 32'h1)
		ahb(1, OMS_OFF_IRQ_CLR, 32'h7);
		ahb(1, OMS_OFF_CTRL, 32'h1);
		repeat (2) @(posedge hclk);
		`CHK(sys_src, 2'h1)
		count_ticks(64, n);
		`CHK(n inside {[6:17]}, 1'b1)
		ahb(0, OMS_OFF_IRQ_STAT, 0);
		`CHK({rd, irq}, {32'h4, 1'b0})
		ahb(1, OMS_OFF_IRQ_EN, 32'h4);
		repeat (2) @(posedge hclk);
		`CHK(irq, 1'b1)
		ahb(1, OMS_OFF_IRQ_CLR, 32'h4);
		repeat (2) @(posedge hclk);
		`CHK(irq, 1'b0)
		for (int k = 0; k < 3; k++) begin
			ahb(1, OMS_OFF_CTRL, {25'h0, 2'(k), 5'h2});
			repeat (8) @(posedge hclk);
			count_ticks(120, n);
			`CHK(sys_src, 2'h2)
			`CHK(n inside {[120 / divs[k] - 2 : 120 / divs[k] + 2]}, 1'b1)
		end
		ahb(1, OMS_OFF_CFG, 32'h7f);
		ahb(0, OMS_OFF_CFG, 0);
		`CHK(rd, 32'h7)
		ahb(0, 8'h20, 0);
		`CHK({rd, hresp}, 33'h0)
		$display("test switch and interrupt done");
	endtask
	task automatic t_static_fail();
		int n;
		do_reset(7'h07);
		wait_run(n);
		osc_run <= 1'b0;
		// Edges already launched still cross the synchroniser
		repeat (8) @(posedge hclk);
		count_ticks(60, n);
		`CHK({n, core_hold, sys_src}, {32'h0, 1'b0, 2'h0})
		osc_run <= 1'b1;
		clk_en <= 1'b0;
		count_ticks(20, n);
		clk_en <= 1'b1;
		`CHK(n, 0)
		count_ticks(40, n);
		`CHK(n > 0, 1'b1)
		do_reset(7'h42);
		wait_run(n);
		ahb(1, OMS_OFF_IRQ_EN, 32'h2);
		osc_run <= 1'b0;
		repeat (40) @(posedge hclk);
		`CHK({sys_src, irq}, 3'h5)
		ahb(0, OMS_OFF_STATUS, 0);
		`CHK(rd[8], 1'b1)
		osc_run <= 1'b1;
		$display("test static and failure done");
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		t_modes();
		t_hold_sleep();
		t_mult_pin();
		t_switch_irq();
		t_static_fail();
		end_of_test();
	end
	// The tests need about 2000 cycles; a far longer wait means a hang
	initial begin
		repeat (30000) @(posedge hclk);
		mismatches++;
		end_of_test();
	end
endmodule
`default_nettype wire
